// *** shared/lsr_pkg.sv ***
/*
  constants, field layouts, carrier types and decode helpers for the slot routing
  and third emitter driver configuration bank.
  assumes one 40 MHz clock and a host that reaches the bank over a two-wire serial port.
*/
// What this block does
// - second slot diode group at bits 11:8, reset 5
// - first slot diode group at bits 7:4, reset 4
// - group codes 1,4,5 connect all/upper/lower inputs
// - second slot emitter choice at bits 3:2, reset 0
// - first slot emitter choice at bits 1:0, reset 1
// - emitter codes 1..3 pick driver; 0 reserved
// - strength bit 13 resets 1; clear gives 40 percent
// - edge rate bits 6:4, reset 0, 7 fastest
// - coarse current bits 3:0, reset 0
// - scale factor is 0.4 plus 0.6 times strength
`default_nettype none
package lsr_pkg;
  // register offsets on the serial port
  localparam logic [7:0] LSR_SLOT_MAP_OFS = 8'h14;
  localparam logic [7:0] LSR_DRV3_OFS = 8'h22;
  // slot map field positions (low bit of each field)
  localparam int LSR_B_GROUP_LSB = 8;
  localparam int LSR_A_GROUP_LSB = 4;
  localparam int LSR_B_EMIT_LSB = 2;
  localparam int LSR_A_EMIT_LSB = 0;
  // third driver field positions
  localparam int LSR_STRENGTH_POS = 13;
  localparam int LSR_FIXED_ONE_POS = 12;
  localparam int LSR_EDGE_LSB = 4;
  localparam int LSR_COARSE_LSB = 0;
  // field reset values
  localparam logic [3:0] LSR_B_GROUP_RST = 4'h5;
  localparam logic [3:0] LSR_A_GROUP_RST = 4'h4;
  localparam logic [1:0] LSR_B_EMIT_RST = 2'h0;
  localparam logic [1:0] LSR_A_EMIT_RST = 2'h1;
  localparam logic LSR_STRENGTH_RST = 1'b1;
  localparam logic [2:0] LSR_EDGE_RST = 3'h0;
  localparam logic [3:0] LSR_COARSE_RST = 4'h0;
  // diode group codes
  localparam logic [3:0] LSR_GROUP_ALL = 4'h1;
  localparam logic [3:0] LSR_GROUP_UPPER = 4'h4;
  localparam logic [3:0] LSR_GROUP_LOWER = 4'h5;
  // scale factor in percent: low power floor and full strength
  localparam logic [6:0] LSR_SCALE_LOW_PCT = 7'h28;
  localparam logic [6:0] LSR_SCALE_FULL_PCT = 7'h64;
  // serial port: bits per byte and the arbitrary default device address
  localparam logic [3:0] LSR_BYTE_BITS = 4'h8;
  localparam logic [6:0] LSR_DEV_ADDR_DEF = 7'h2A; // value is arbitrary
  // slot map fields
  typedef struct packed {
    logic [3:0] second_slot_diode_group;
    logic [3:0] first_slot_diode_group;
    logic [1:0] second_slot_emitter_choice;
    logic [1:0] first_slot_emitter_choice;
  } lsr_slot_map_type;
  // third driver fields
  typedef struct packed {
    logic third_driver_strength_bit;
    logic [2:0] third_driver_edge_rate;
    logic [3:0] third_driver_coarse_current;
  } lsr_drv3_type;
  // serial engine states
  typedef enum logic [4:0] {
    LSR_IDLE = 5'h01,
    LSR_RX = 5'h02,
    LSR_ACK = 5'h04,
    LSR_TX = 5'h08,
    LSR_MACK = 5'h10
  } lsr_state_type;
  // which byte of a transfer is being received
  typedef enum logic [3:0] {
    LSR_PH_DEV = 4'h1,
    LSR_PH_REG = 4'h2,
    LSR_PH_WHI = 4'h4,
    LSR_PH_WLO = 4'h8
  } lsr_phase_type;
  // diode group code to an eight-input connect mask; reserved codes connect nothing
  function automatic logic [7:0] lsr_group_mask(input logic [3:0] code);
    case (code)
      LSR_GROUP_ALL: lsr_group_mask = 8'hFF;
      LSR_GROUP_UPPER: lsr_group_mask = 8'hF0;
      LSR_GROUP_LOWER: lsr_group_mask = 8'h0F;
      default: lsr_group_mask = 8'h00;
    endcase
  endfunction : lsr_group_mask
  // emitter code to one-hot driver enable; code 0 pulses none
  function automatic logic [2:0] lsr_emit_onehot(input logic [1:0] code);
    case (code)
      2'h1: lsr_emit_onehot = 3'h1;
      2'h2: lsr_emit_onehot = 3'h2;
      2'h3: lsr_emit_onehot = 3'h4;
      default: lsr_emit_onehot = 3'h0;
    endcase
  endfunction : lsr_emit_onehot
endpackage : lsr_pkg
`default_nettype wire

// *** hdl/lsr_sync2.sv ***
/*
  two flip-flop synchroniser for the serial clock and data pins.
  assumes pins idle high, so both stages reset to one.
*/
`default_nettype none
module lsr_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [1:0] async_in,
  output logic [1:0] sync_out
);
  logic [1:0] meta_ff; // first stage, read only by the second
  // two stage capture
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_ff <= 2'h3;
      sync_out <= 2'h3;
    end else begin
      meta_ff <= async_in;
      sync_out <= meta_ff;
    end
  end
endmodule : lsr_sync2
`default_nettype wire

// *** hdl/lsr_config_bank.sv ***
/*
  slot routing and third emitter driver configuration bank behind a two-wire
  serial slave: device address, register offset, then 16-bit data high byte first.
  assumes scl and sda arrive asynchronously and the sda pad is open drain.
*/
`default_nettype none
module lsr_config_bank #(
  parameter logic [6:0] DEV_ADDR = lsr_pkg::LSR_DEV_ADDR_DEF
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n,
  output lsr_pkg::lsr_slot_map_type slot_map,
  output lsr_pkg::lsr_drv3_type drv3,
  output logic [7:0] first_slot_diode_input_en,
  output logic [7:0] second_slot_diode_input_en,
  output logic [2:0] first_slot_emitter_en,
  output logic [2:0] second_slot_emitter_en,
  output logic [6:0] third_driver_scale_pct
);
  logic [1:0] pins_s; // synchronised {scl, sda}
  logic scl_s;
  logic sda_s;
  logic scl_q_ff; // previous synchronised levels for edges
  logic sda_q_ff;
  logic scl_rise;
  logic scl_fall;
  logic start_seen;
  logic stop_seen;

  lsr_sync2 u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({scl_i, sda_i}),
    .sync_out(pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];
  assign scl_rise = scl_s & ~scl_q_ff;
  assign scl_fall = ~scl_s & scl_q_ff;
  // start and stop are sda edges while scl stays high
  assign start_seen = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
  assign stop_seen = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

  // serial engine state
  lsr_pkg::lsr_state_type st_ff, nxt_st;
  lsr_pkg::lsr_phase_type ph_ff, nxt_ph;
  logic [3:0] bit_cnt_ff, nxt_bit_cnt;
  logic [7:0] shreg_ff, nxt_shreg;
  logic rw_ff, nxt_rw; // one when the host reads
  logic [7:0] reg_addr_ff, nxt_reg_addr;
  logic [7:0] whi_ff, nxt_whi; // held high byte of a write
  logic lo_next_ff, nxt_lo_next; // next read byte is the low one
  logic oe_n_ff, nxt_oe_n;
  logic wr_ff, nxt_wr; // one-cycle commit strobe
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata; // read image of the addressed register

  // read image; reserved bits show their required values
  // readback of fields
  always_comb begin
    rdata = 16'h0000;
    if (reg_addr_ff == lsr_pkg::LSR_SLOT_MAP_OFS) begin
      rdata[lsr_pkg::LSR_B_GROUP_LSB +: 4] = slot_map.second_slot_diode_group;
      rdata[lsr_pkg::LSR_A_GROUP_LSB +: 4] = slot_map.first_slot_diode_group;
      rdata[lsr_pkg::LSR_B_EMIT_LSB +: 2] = slot_map.second_slot_emitter_choice;
      rdata[lsr_pkg::LSR_A_EMIT_LSB +: 2] = slot_map.first_slot_emitter_choice;
    end else if (reg_addr_ff == lsr_pkg::LSR_DRV3_OFS) begin
      rdata[lsr_pkg::LSR_STRENGTH_POS] = drv3.third_driver_strength_bit;
      rdata[lsr_pkg::LSR_FIXED_ONE_POS] = 1'b1;
      rdata[lsr_pkg::LSR_EDGE_LSB +: 3] = drv3.third_driver_edge_rate;
      rdata[lsr_pkg::LSR_COARSE_LSB +: 4] = drv3.third_driver_coarse_current;
    end
  end

  // next state of the serial engine
  always_comb begin
    nxt_st = st_ff;
    nxt_ph = ph_ff;
    nxt_bit_cnt = bit_cnt_ff;
    nxt_shreg = shreg_ff;
    nxt_rw = rw_ff;
    nxt_reg_addr = reg_addr_ff;
    nxt_whi = whi_ff;
    nxt_lo_next = lo_next_ff;
    nxt_oe_n = oe_n_ff;
    nxt_wr = 1'b0;
    nxt_wdata = wdata_ff;
    if (start_seen) begin
      // a start, repeated or not, restarts address reception
      nxt_st = lsr_pkg::LSR_RX;
      nxt_ph = lsr_pkg::LSR_PH_DEV;
      nxt_bit_cnt = 4'h0;
      nxt_oe_n = 1'b1;
    end else if (stop_seen) begin
      nxt_st = lsr_pkg::LSR_IDLE;
      nxt_oe_n = 1'b1;
    end else begin
      case (st_ff)
        lsr_pkg::LSR_IDLE: begin
          nxt_oe_n = 1'b1;
        end
        lsr_pkg::LSR_RX: begin
          if (scl_rise) begin
            nxt_shreg = {shreg_ff[6:0], sda_s};
            nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
          end else if (scl_fall && bit_cnt_ff == lsr_pkg::LSR_BYTE_BITS) begin
            nxt_st = lsr_pkg::LSR_ACK;
            nxt_oe_n = 1'b0;
            case (ph_ff)
              lsr_pkg::LSR_PH_DEV: begin
                nxt_rw = shreg_ff[0];
                nxt_lo_next = 1'b0;
                // foreign address: stay off the bus until the next start
                if (shreg_ff[7:1] != DEV_ADDR) begin
                  nxt_st = lsr_pkg::LSR_IDLE;
                  nxt_oe_n = 1'b1;
                end
              end
              lsr_pkg::LSR_PH_REG: nxt_reg_addr = shreg_ff;
              lsr_pkg::LSR_PH_WHI: nxt_whi = shreg_ff;
              lsr_pkg::LSR_PH_WLO: begin
                // second data byte commits the whole word at once
                nxt_wr = 1'b1;
                nxt_wdata = {whi_ff, shreg_ff};
              end
              default: nxt_st = lsr_pkg::LSR_IDLE;
            endcase
          end
        end
        lsr_pkg::LSR_ACK: begin
          if (scl_fall) begin
            nxt_bit_cnt = 4'h0;
            nxt_oe_n = 1'b1;
            nxt_st = lsr_pkg::LSR_RX;
            if (ph_ff == lsr_pkg::LSR_PH_DEV && rw_ff) begin
              // read: first data bit goes out on this same fall
              nxt_st = lsr_pkg::LSR_TX;
              nxt_shreg = rdata[15:8];
              nxt_oe_n = rdata[15];
              nxt_lo_next = 1'b1;
            end else if (ph_ff == lsr_pkg::LSR_PH_DEV) begin
              nxt_ph = lsr_pkg::LSR_PH_REG;
            end else if (ph_ff == lsr_pkg::LSR_PH_REG) begin
              nxt_ph = lsr_pkg::LSR_PH_WHI;
            end else if (ph_ff == lsr_pkg::LSR_PH_WHI) begin
              nxt_ph = lsr_pkg::LSR_PH_WLO;
            end else begin
              // bytes past one word are not acknowledged
              nxt_st = lsr_pkg::LSR_IDLE;
            end
          end
        end
        lsr_pkg::LSR_TX: begin
          if (scl_rise) begin
            nxt_bit_cnt = 4'(bit_cnt_ff + 4'h1);
          end else if (scl_fall) begin
            if (bit_cnt_ff == lsr_pkg::LSR_BYTE_BITS) begin
              nxt_oe_n = 1'b1;
              nxt_st = lsr_pkg::LSR_MACK;
            end else begin
              nxt_shreg = {shreg_ff[6:0], 1'b0};
              nxt_oe_n = shreg_ff[6];
            end
          end
        end
        lsr_pkg::LSR_MACK: begin
          if (scl_rise && sda_s) begin
            // host declined more data
            nxt_st = lsr_pkg::LSR_IDLE;
          end else if (scl_fall) begin
            // host wants more: alternate low and high bytes
            nxt_bit_cnt = 4'h0;
            nxt_st = lsr_pkg::LSR_TX;
            nxt_shreg = lo_next_ff ? rdata[7:0] : rdata[15:8];
            nxt_oe_n = lo_next_ff ? rdata[7] : rdata[15];
            nxt_lo_next = ~lo_next_ff;
          end
        end
        default: begin
          nxt_st = lsr_pkg::LSR_IDLE;
          nxt_oe_n = 1'b1;
        end
      endcase
    end
  end

  // serial engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q_ff <= 1'b1;
      sda_q_ff <= 1'b1;
      st_ff <= lsr_pkg::LSR_IDLE;
      ph_ff <= lsr_pkg::LSR_PH_DEV;
      bit_cnt_ff <= 4'h0;
      shreg_ff <= 8'h00;
      rw_ff <= 1'b0;
      reg_addr_ff <= 8'h00;
      whi_ff <= 8'h00;
      lo_next_ff <= 1'b0;
      oe_n_ff <= 1'b1;
      wr_ff <= 1'b0;
      wdata_ff <= 16'h0000;
    end else begin
      scl_q_ff <= scl_s;
      sda_q_ff <= sda_s;
      st_ff <= nxt_st;
      ph_ff <= nxt_ph;
      bit_cnt_ff <= nxt_bit_cnt;
      shreg_ff <= nxt_shreg;
      rw_ff <= nxt_rw;
      reg_addr_ff <= nxt_reg_addr;
      whi_ff <= nxt_whi;
      lo_next_ff <= nxt_lo_next;
      oe_n_ff <= nxt_oe_n;
      wr_ff <= nxt_wr;
      wdata_ff <= nxt_wdata;
    end
  end
  assign sda_oe_n = oe_n_ff;

  // configuration fields and their decoded controls
  lsr_pkg::lsr_slot_map_type nxt_slot_map;
  lsr_pkg::lsr_drv3_type nxt_drv3;
  logic [7:0] nxt_a_din, nxt_b_din;
  logic [2:0] nxt_a_emit, nxt_b_emit;
  logic [6:0] nxt_scale;

  // field update on a committed write; reserved bits are dropped, since
  // software owes them fixed values and nothing here depends on them
  always_comb begin
    nxt_slot_map = slot_map;
    nxt_drv3 = drv3;
    if (wr_ff && reg_addr_ff == lsr_pkg::LSR_SLOT_MAP_OFS) begin
      nxt_slot_map.second_slot_diode_group = wdata_ff[lsr_pkg::LSR_B_GROUP_LSB +: 4];
      nxt_slot_map.first_slot_diode_group = wdata_ff[lsr_pkg::LSR_A_GROUP_LSB +: 4];
      nxt_slot_map.second_slot_emitter_choice = wdata_ff[lsr_pkg::LSR_B_EMIT_LSB +: 2];
      nxt_slot_map.first_slot_emitter_choice = wdata_ff[lsr_pkg::LSR_A_EMIT_LSB +: 2];
    end
    if (wr_ff && reg_addr_ff == lsr_pkg::LSR_DRV3_OFS) begin
      nxt_drv3.third_driver_strength_bit = wdata_ff[lsr_pkg::LSR_STRENGTH_POS];
      nxt_drv3.third_driver_edge_rate = wdata_ff[lsr_pkg::LSR_EDGE_LSB +: 3];
      nxt_drv3.third_driver_coarse_current = wdata_ff[lsr_pkg::LSR_COARSE_LSB +: 4];
    end
    nxt_a_din = lsr_pkg::lsr_group_mask(nxt_slot_map.first_slot_diode_group);
    nxt_b_din = lsr_pkg::lsr_group_mask(nxt_slot_map.second_slot_diode_group);
    nxt_a_emit = lsr_pkg::lsr_emit_onehot(nxt_slot_map.first_slot_emitter_choice);
    nxt_b_emit = lsr_pkg::lsr_emit_onehot(nxt_slot_map.second_slot_emitter_choice);
    nxt_scale = nxt_drv3.third_driver_strength_bit ? lsr_pkg::LSR_SCALE_FULL_PCT
                                                   : lsr_pkg::LSR_SCALE_LOW_PCT;
  end

  // field registers; decoded outputs change in the same cycle as the fields
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_map <= '{lsr_pkg::LSR_B_GROUP_RST, lsr_pkg::LSR_A_GROUP_RST,
                    lsr_pkg::LSR_B_EMIT_RST, lsr_pkg::LSR_A_EMIT_RST};
      drv3 <= '{lsr_pkg::LSR_STRENGTH_RST, lsr_pkg::LSR_EDGE_RST, lsr_pkg::LSR_COARSE_RST};
      first_slot_diode_input_en <= 8'hF0;
      second_slot_diode_input_en <= 8'h0F;
      first_slot_emitter_en <= 3'h1;
      second_slot_emitter_en <= 3'h0;
      third_driver_scale_pct <= lsr_pkg::LSR_SCALE_FULL_PCT;
      sda_o <= 1'b0;
    end else begin
      slot_map <= nxt_slot_map;
      drv3 <= nxt_drv3;
      first_slot_diode_input_en <= nxt_a_din;
      second_slot_diode_input_en <= nxt_b_din;
      first_slot_emitter_en <= nxt_a_emit;
      second_slot_emitter_en <= nxt_b_emit;
      third_driver_scale_pct <= nxt_scale;
      sda_o <= 1'b0; // open drain: only ever pulls low
    end
  end

  // checks: helper flag marks that some write has been committed
  logic wr_seen_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) wr_seen_ff <= 1'b0;
    else if (wr_ff) wr_seen_ff <= 1'b1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  b_group_rst_a: assert property (!wr_seen_ff |->
    slot_map.second_slot_diode_group == lsr_pkg::LSR_B_GROUP_RST)
    else $error("second slot group not at reset code");
  a_group_rst_a: assert property (!wr_seen_ff |->
    slot_map.first_slot_diode_group == lsr_pkg::LSR_A_GROUP_RST)
    else $error("first slot group not at reset code");
  group_decode_a: assert property (
    first_slot_diode_input_en == lsr_pkg::lsr_group_mask(slot_map.first_slot_diode_group)
    && second_slot_diode_input_en == lsr_pkg::lsr_group_mask(slot_map.second_slot_diode_group))
    else $error("diode connect mask does not match group code");
  b_emit_rst_a: assert property (!wr_seen_ff |->
    slot_map.second_slot_emitter_choice == lsr_pkg::LSR_B_EMIT_RST)
    else $error("second slot emitter not at reset code");
  a_emit_rst_a: assert property (!wr_seen_ff |->
    slot_map.first_slot_emitter_choice == lsr_pkg::LSR_A_EMIT_RST)
    else $error("first slot emitter not at reset code");
  emit_decode_a: assert property (
    first_slot_emitter_en == lsr_pkg::lsr_emit_onehot(slot_map.first_slot_emitter_choice)
    && second_slot_emitter_en == lsr_pkg::lsr_emit_onehot(slot_map.second_slot_emitter_choice))
    else $error("emitter enable does not match choice");
  drv3_rst_a: assert property (!wr_seen_ff |-> drv3.third_driver_strength_bit
    && third_driver_scale_pct == lsr_pkg::LSR_SCALE_FULL_PCT)
    else $error("strength not full after reset");
  edge_rst_a: assert property (!wr_seen_ff |->
    drv3.third_driver_edge_rate == 3'h0) else $error("edge rate not at reset");
  coarse_rst_a: assert property (!wr_seen_ff |->
    drv3.third_driver_coarse_current == 4'h0) else $error("coarse code not at reset");
  scale_pct_a: assert property (third_driver_scale_pct ==
    (drv3.third_driver_strength_bit ? lsr_pkg::LSR_SCALE_FULL_PCT : lsr_pkg::LSR_SCALE_LOW_PCT))
    else $error("scale percent does not follow strength bit");
  map_write_a: assert property (wr_ff && reg_addr_ff == lsr_pkg::LSR_SLOT_MAP_OFS
    |=> slot_map == {$past(wdata_ff[11:0])}) else $error("slot map write not stored");
  drv3_write_a: assert property (wr_ff && reg_addr_ff == lsr_pkg::LSR_DRV3_OFS
    |=> drv3 == {$past(wdata_ff[13]), $past(wdata_ff[6:0])})
    else $error("driver write not stored");
  map_wr_c: cover property (wr_ff && reg_addr_ff == lsr_pkg::LSR_SLOT_MAP_OFS);
  drv3_wr_c: cover property (wr_ff && reg_addr_ff == lsr_pkg::LSR_DRV3_OFS);
  read_c: cover property (st_ff == lsr_pkg::LSR_MACK ##[1:400] st_ff == lsr_pkg::LSR_TX);
endmodule : lsr_config_bank
`default_nettype wire

// *** dv/lsr_config_bank_tb_top.sv ***
/*
  self-checking bench for the slot routing and third driver configuration bank.
  assumes the bench is the only host on the open-drain serial bus, with a pull-up on sda.
*/
`default_nettype none
module lsr_config_bank_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [6:0] DEV = lsr_pkg::LSR_DEV_ADDR_DEF;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_i = 1'b1;
  logic host_sda = 1'b1; // host side of sda, one means released
  logic sda_o;
  logic sda_oe_n;
  lsr_pkg::lsr_slot_map_type slot_map;
  lsr_pkg::lsr_drv3_type drv3;
  logic [7:0] a_din_en;
  logic [7:0] b_din_en;
  logic [2:0] a_emit_en;
  logic [2:0] b_emit_en;
  logic [6:0] scale_pct;
  int failures = 0;
  int samples_checked = 0;
  // wired-and of both parties; pull-up wins when nobody pulls low
  wire sda_wire = host_sda & (sda_oe_n | sda_o);
  lsr_config_bank #(.DEV_ADDR(DEV)) u_dut (
    .clk(clk), .rst_n(rst_n), .scl_i(scl_i), .sda_i(sda_wire), .sda_o(sda_o),
    .sda_oe_n(sda_oe_n), .slot_map(slot_map), .drv3(drv3),
    .first_slot_diode_input_en(a_din_en), .second_slot_diode_input_en(b_din_en),
    .first_slot_emitter_en(a_emit_en), .second_slot_emitter_en(b_emit_en),
    .third_driver_scale_pct(scale_pct)
  );
  // 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end
  task automatic print_verdict();
    $display("checked %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // watchdog: a hang counts as a failure
  initial begin
    repeat (50000) @(posedge clk);
    failures++;
    print_verdict();
  end
  task automatic check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask : check_word
  task automatic check_bit(input string name, input logic exp, input logic got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %b seen %b", name, exp, got);
    end
  endtask : check_bit
  // wait n clocks, then step off the edge so pin changes never race it
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick
  // sda moves 3 clk after scl falls so the synchronisers see clean hold
  task automatic put_bit(input logic b);
    tick(3);
    host_sda = b;
    tick(5);
    scl_i = 1'b1;
    tick(6);
    scl_i = 1'b0;
  endtask : put_bit
  task automatic get_bit(output logic b);
    tick(3);
    host_sda = 1'b1;
    tick(5);
    scl_i = 1'b1;
    tick(3);
    b = sda_wire;
    tick(3);
    scl_i = 1'b0;
  endtask : get_bit
  // also serves as repeated start when scl is low
  task automatic start_c();
    tick(3);
    host_sda = 1'b1;
    tick(5);
    scl_i = 1'b1;
    tick(6);
    host_sda = 1'b0;
    tick(6);
    scl_i = 1'b0;
  endtask : start_c
  task automatic stop_c();
    tick(3);
    host_sda = 1'b0;
    tick(5);
    scl_i = 1'b1;
    tick(6);
    host_sda = 1'b1;
    tick(6);
  endtask : stop_c
  task automatic send_byte(input logic [7:0] b, output logic ack_lvl);
    for (int i = 7; i >= 0; i--) begin
      put_bit(b[i]);
    end
    get_bit(ack_lvl);
  endtask : send_byte
  task automatic get_byte(output logic [7:0] b, input logic host_ack);
    for (int i = 7; i >= 0; i--) begin
      get_bit(b[i]);
    end
    put_bit(host_ack);
  endtask : get_byte
  // write frame: nb data bytes, every ack expected at level ea
  task automatic wr_frame(input logic [6:0] dev, input logic [7:0] ofs, input logic [15:0] d,
                          input int nb, input logic ea);
    logic a;
    start_c();
    send_byte({dev, 1'b0}, a);
    check_bit("addr ack", ea, a);
    send_byte(ofs, a);
    check_bit("offset ack", ea, a);
    for (int i = 0; i < nb; i++) begin
      send_byte((i == 0) ? d[15:8] : d[7:0], a);
      check_bit("data ack", ea, a);
    end
    stop_c();
    tick(10);
  endtask : wr_frame
  // read frame: offset, repeated start, hi byte acked, lo byte refused
  task automatic rd16(input logic [7:0] ofs, output logic [15:0] d);
    logic a;
    logic [7:0] hi;
    logic [7:0] lo;
    start_c();
    send_byte({DEV, 1'b0}, a);
    send_byte(ofs, a);
    start_c();
    send_byte({DEV, 1'b1}, a);
    check_bit("read addr ack", 1'b0, a);
    get_byte(hi, 1'b0);
    get_byte(lo, 1'b1);
    stop_c();
    tick(4);
    d = {hi, lo};
  endtask : rd16
  // bench's own decode of group and emitter codes
  function automatic logic [7:0] grp(input logic [3:0] c);
    case (c)
      4'h1: grp = 8'hFF;
      4'h4: grp = 8'hF0;
      4'h5: grp = 8'h0F;
      default: grp = 8'h00;
    endcase
  endfunction : grp
  function automatic logic [2:0] emit(input logic [1:0] c);
    emit = (c == 2'h0) ? 3'h0 : (3'h1 << (c - 2'h1));
  endfunction : emit
  // port view expected from register images m (slot map) and t (third driver)
  task automatic check_outs(input logic [15:0] m, input logic [15:0] t);
    check_word("slot_map", {4'h0, m[11:0]}, {4'h0, slot_map});
    check_word("drv3", {8'h00, t[13], t[6:0]}, {8'h00, drv3});
    check_word("a inputs", {8'h00, grp(m[7:4])}, {8'h00, a_din_en});
    check_word("b inputs", {8'h00, grp(m[11:8])}, {8'h00, b_din_en});
    check_word("a emitter", {13'h0, emit(m[1:0])}, {13'h0, a_emit_en});
    check_word("b emitter", {13'h0, emit(m[3:2])}, {13'h0, b_emit_en});
    check_word("scale", t[13] ? 16'h0064 : 16'h0028, {9'h000, scale_pct});
  endtask : check_outs
  task automatic check_all(input logic [15:0] m, input logic [15:0] t);
    logic [15:0] r;
    rd16(8'h14, r);
    check_word("slot map read", m, r);
    rd16(8'h22, r);
    check_word("driver read", t, r);
    check_outs(m, t);
  endtask : check_all
  initial begin
    logic [15:0] r;
    logic [15:0] m_tbl [3];
    logic [15:0] t_tbl [3];
    // every group code and emitter codes 1..3 in each slot; reserved bits zero, bit 12 one
    m_tbl = '{16'h0159, 16'h041E, 16'h0547};
    t_tbl = '{16'h107F, 16'h3025, 16'h1000};
    tick(12);
    rst_n = 1'b1;
    tick(4);
    check_all(16'h0541, 16'h3000);
    for (int i = 0; i < 3; i++) begin
      wr_frame(DEV, 8'h14, m_tbl[i], 2, 1'b0);
      wr_frame(DEV, 8'h22, t_tbl[i], 2, 1'b0);
      check_all(m_tbl[i], t_tbl[i]);
    end
    // a lone high byte must not commit anything
    wr_frame(DEV, 8'h14, 16'h0100, 1, 1'b0);
    check_all(16'h0547, 16'h1000);
    // another device address is ignored entirely
    wr_frame(DEV ^ 7'h01, 8'h14, 16'h0159, 2, 1'b1);
    check_all(16'h0547, 16'h1000);
    // unmapped offset: acked, dropped, reads zero
    wr_frame(DEV, 8'h30, 16'h0159, 2, 1'b0);
    rd16(8'h30, r);
    check_word("unmapped read", 16'h0000, r);
    check_all(16'h0547, 16'h1000);
    // reset in mid-run brings every field back to its default
    rst_n = 1'b0;
    tick(3);
    check_outs(16'h0541, 16'h3000);
    rst_n = 1'b1;
    tick(4);
    check_all(16'h0541, 16'h3000);
    print_verdict();
  end
endmodule : lsr_config_bank_tb_top
`default_nettype wire
